// file: inc/cap_pkg.sv
// shared constants and carrier types for the channel autopositioner sequencer
`default_nettype none
package cap_pkg;
    localparam int unsigned ADDR_W        = 6;
    localparam int unsigned DATA_W        = 32;
    // register map (word index on the plain register port)
    localparam logic [5:0]  ADDR_PRESET0  = 6'h00;    // 33 preset words, channel*3+digit
    localparam logic [5:0]  ADDR_POSITION = 6'h21;
    localparam logic [5:0]  ADDR_STATUS   = 6'h22;
    // position field layout in the position word
    localparam int unsigned POS_CHAN_LSB  = 0;
    localparam int unsigned POS_TENS_LSB  = 4;
    localparam int unsigned POS_UNITS_LSB = 12;
    localparam int unsigned POS_TENTH_LSB = 16;
    // status word layout
    localparam int unsigned ST_FREQ_LSB   = 16;
    // counts
    localparam int unsigned CHANNELS      = 11;       // manual plus ten presets
    localparam int unsigned DIGITS        = 3;
    localparam int unsigned PRESETS       = 33;
    localparam int unsigned FREQ_COUNT    = 1750;
    localparam logic [3:0]  CHAN_LAST     = 4'hA;
    localparam logic [3:0]  SEL_REMOTE    = 4'hB;     // local selector set to remote
    localparam logic [3:0]  REMOTE_MIN    = 4'h1;
    localparam logic [3:0]  REMOTE_MAX    = 4'hA;
    localparam logic [3:0]  DIGIT_LAST    = 4'h9;
    localparam logic [5:0]  TENS_LAST     = 6'h23;    // 36 electrical positions
    localparam logic [5:0]  SEEKER_POINTS = 6'h0C;    // 12 points per seeker
    localparam logic [5:0]  PHASE1_END    = 6'h09;    // 270 degrees of seeker rotation
    localparam logic [5:0]  PHASE2_END    = 6'h12;    // next 270 degrees
    localparam logic [4:0]  TENS_FREQS    = 5'h12;    // 18 usable 10 mc settings
    localparam logic [11:0] FREQ_TOP_TENS = 12'h186;  // 390 in 1 mc units
    localparam logic [11:0] FREQ_MIN      = 12'h8CA;  // 225.0 mc in 0.1 mc units
    localparam logic [11:0] FREQ_MAX      = 12'hF9F;  // 399.9 mc in 0.1 mc units
    localparam logic [4:0]  PRESET_RESET  = 5'h00;

    typedef enum logic [1:0] {TRK_NORMAL, TRK_OFF, TRK_RUN} cap_track_type;

    typedef struct packed {
        logic chan;
        logic tens;
        logic units;
        logic tenths;
    } cap_drive_type;

    typedef struct packed {
        logic [3:0] chan;
        logic [5:0] tens;
        logic [3:0] units;
        logic [3:0] tenths;
    } cap_pos_type;
endpackage
`default_nettype wire

// file: core/cap_sequencer.sv
// channel autopositioner sequencer: channel seek, digit seek, motor and mute control
//
// Notes on behaviour
// - tunes one of 1750 frequencies between 225.0 and 399.9 mc
// - holds 33 preset digits: 11 channels of 10, 1.0 and 0.1 mc
// - local selector or remote input starts a cycle by presenting a channel
// - requested channel differing from channel seeker raises seek request and channel drive
// - seek request inhibits all three digit drives until channel positioning ends
// - motor runs exactly while any of the four drives is active
// - mute is asserted whenever the motor runs
// - channel positioner steps until seeker matches, then seek request and drive drop
// - after channel seek, each digit drive enables where seeker differs from preset
// - 1.0 and 0.1 mc positioners stop and lock when seeker matches preset
// - 10 mc positioner has 36 positions: 18 frequencies, 18 return travel
// - first 270 degrees: first seeker compares its 9 positions, second rejected
// - next 270 degrees: second seeker compares its 9 positions, first rejected
// - last 540 degrees: both seekers rejected, mechanism returns to 390 mc
// - each 10 mc seeker contacts exactly one of front or rear side
// - unused seeker points around phase boundaries never stop the seek
// - tracking selector NORMAL, OFF, RUN; RUN drives 10 mc positioner continuously
// - tracking selector in RUN or OFF keeps mute asserted
// - preset-driven 10 mc seek only in NORMAL
// - cycle complete when all four drives inactive; motor run then drops
//
// Design decisions made here: the register addresses and the strobed register port.
`default_nettype none
module cap_sequencer
    import cap_pkg::*;
(
    input  wire logic                     I_CLOCK,          // 25 MHz system clock
    input  wire logic                     I_RST_N,          // synchronous reset, active low
    input  wire logic [cap_pkg::ADDR_W-1:0] I_ADDR,         // register word address
    input  wire logic [cap_pkg::DATA_W-1:0] I_WDATA,        // register write data
    input  wire logic                     I_WR,             // write strobe
    input  wire logic                     I_RD,             // read strobe
    output var  logic [cap_pkg::DATA_W-1:0] O_RDATA,        // read data, cycle after I_RD
    input  wire logic [3:0]               I_LOCAL_SEL,      // local selector, 0..10 or remote
    input  wire logic [3:0]               I_REMOTE_CODE,    // remote selector code
    input  wire logic [1:0]               I_TRACK_MODE,     // tracking mode selector
    input  wire logic                     I_MOTOR_STEP,     // one pulse per mechanical step
    output var  logic                     O_CHANNEL_SEEK_REQUEST,   // channel seek request
    output var  cap_pkg::cap_drive_type   O_DRIVES,         // four positioner drives
    output var  logic                     O_MOTOR_RUN,      // positioner motor run
    output var  logic                     O_MUTE,           // receiver mute request
    output var  logic [3:0]               O_CHANNEL_ENERGIZE // channel energize / indicator
);
    import cap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [3:0] seeker_point(input logic [5:0] pos);
        logic [5:0] p;
        p = pos;
        if (p >= SEEKER_POINTS) p = p - SEEKER_POINTS;
        if (p >= SEEKER_POINTS) p = p - SEEKER_POINTS;
        return p[3:0];
    endfunction

    // stop-wheel decision of a ten-position digit: open circuit when seeker meets preset
    function automatic logic digit_open(input logic [3:0] pos, input logic [4:0] want);
        return {1'b0, pos} == want;
    endfunction

    // open circuit of the 10 mc seeker pair under the phase blanker
    function automatic logic tens_open(input logic [5:0] pos, input logic [4:0] want);
        logic [3:0] pt;
        logic [4:0] want_b;
        logic       a_front;
        logic       b_front;
        pt      = seeker_point(pos);
        want_b  = (want >= 5'(SEEKER_POINTS)) ? want - 5'(SEEKER_POINTS) : want;
        // one blade side per point: rear is the complement, so a point is open on one side only
        a_front = (want < 5'(PHASE1_END)) && ({1'b0, pt} == want);
        b_front = (want >= 5'(PHASE1_END)) && (want < TENS_FREQS)
                  && ({1'b0, pt} == want_b);
        // points outside each seeker's 9 active ones never open, so the blanker's
        // switch-over moment is tolerant
        if (pos < PHASE1_END) return a_front;
        else if (pos < PHASE2_END) return b_front;
        else return 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [4:0]     preset_ff [PRESETS];
    cap_pos_type    pos_ff;
    logic           pos_known_ff;
    logic [3:0]     req_chan_ff;
    logic           seek_ff;
    cap_drive_type  drive_ff;
    logic           motor_ff;
    logic           mute_ff;
    logic [3:0]     energize_ff;
    logic [DATA_W-1:0] rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // channel request and sequencing

    cap_track_type  track;
    logic [3:0]     nxt_req_chan;
    logic           remote_ok;
    logic           nxt_seek;
    logic [5:0]     pre_base;
    logic [4:0]     want_tens;
    logic [4:0]     want_units;
    logic [4:0]     want_tenths;
    cap_drive_type  nxt_drive;
    logic           nxt_motor;
    logic           nxt_mute;
    logic           run_ok;
    logic           step;
    cap_pos_type    nxt_pos;

    assign track        = cap_track_type'(I_TRACK_MODE);
    assign remote_ok    = (I_REMOTE_CODE >= REMOTE_MIN) && (I_REMOTE_CODE <= REMOTE_MAX);
    // an unusable remote code or selector value leaves the last request standing
    assign nxt_req_chan = (I_LOCAL_SEL == SEL_REMOTE) ? (remote_ok ? I_REMOTE_CODE
                                                                   : req_chan_ff)
                        : (I_LOCAL_SEL <= CHAN_LAST) ? I_LOCAL_SEL : req_chan_ff;
    assign nxt_seek     = pos_known_ff && (req_chan_ff != pos_ff.chan);

    assign pre_base     = 6'(pos_ff.chan * DIGITS);
    assign want_tens    = preset_ff[pre_base];
    assign want_units   = preset_ff[pre_base + 6'h01];
    assign want_tenths  = preset_ff[pre_base + 6'h02];

    // digit drives take over on the edge the seek request drops, so motor and
    // mute never show a false idle cycle between channel and digit positioning
    assign nxt_drive.chan   = nxt_seek;
    assign nxt_drive.units  = pos_known_ff && !nxt_seek
                              && !digit_open(pos_ff.units, want_units);
    assign nxt_drive.tenths = pos_known_ff && !nxt_seek
                              && !digit_open(pos_ff.tenths, want_tenths);
    assign nxt_drive.tens   = pos_known_ff && !nxt_seek
                              && ((track == TRK_RUN)
                                  || ((track == TRK_NORMAL)
                                      && !tens_open(pos_ff.tens, want_tens)));
    assign nxt_motor    = |nxt_drive;
    assign nxt_mute     = nxt_motor || (track == TRK_RUN) || (track == TRK_OFF);

    assign run_ok = motor_ff && I_MOTOR_STEP;
    assign step   = run_ok;

    always_comb begin
        nxt_pos = pos_ff;
        if (step && drive_ff.chan) begin
            nxt_pos.chan = (pos_ff.chan == CHAN_LAST) ? 4'h0 : pos_ff.chan + 4'h1;
        end
        if (step && drive_ff.tens) begin
            nxt_pos.tens = (pos_ff.tens == TENS_LAST) ? 6'h00 : pos_ff.tens + 6'h01;
        end
        if (step && drive_ff.units) begin
            nxt_pos.units = (pos_ff.units == DIGIT_LAST) ? 4'h0 : pos_ff.units + 4'h1;
        end
        if (step && drive_ff.tenths) begin
            nxt_pos.tenths = (pos_ff.tenths == DIGIT_LAST) ? 4'h0 : pos_ff.tenths + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tuned frequency in 0.1 mc units

    logic [11:0] tens_mc;
    logic [11:0] freq;
    logic        freq_valid;

    assign tens_mc    = FREQ_TOP_TENS - 12'(pos_ff.tens * 10);
    assign freq       = 12'(tens_mc * 10) + 12'(pos_ff.units * 10) + 12'(pos_ff.tenths);
    assign freq_valid = (pos_ff.tens < 6'(TENS_FREQS)) && (freq >= FREQ_MIN)
                        && (freq <= FREQ_MAX);

    ////////////////////////////////////////////////////////////////////////////////
    // register port

    logic              wr_preset;
    logic              wr_pos;
    logic [DATA_W-1:0] rd_mux;
    cap_pos_type       wr_pos_val;

    assign wr_preset  = I_WR && (I_ADDR < 6'(PRESETS));
    assign wr_pos     = I_WR && (I_ADDR == ADDR_POSITION);
    assign wr_pos_val = '{chan:   I_WDATA[POS_CHAN_LSB +: 4],
                          tens:   I_WDATA[POS_TENS_LSB +: 6],
                          units:  I_WDATA[POS_UNITS_LSB +: 4],
                          tenths: I_WDATA[POS_TENTH_LSB +: 4]};
    assign rd_mux = (I_ADDR < 6'(PRESETS)) ? {27'h0, preset_ff[I_ADDR]}
                  : (I_ADDR == ADDR_POSITION) ? {12'h0, pos_ff.tenths, pos_ff.units,
                                                 2'h0, pos_ff.tens, pos_ff.chan}
                  : (I_ADDR == ADDR_STATUS) ? {4'h0, freq, 3'h0, freq_valid,
                                               pos_known_ff, req_chan_ff, mute_ff,
                                               motor_ff, drive_ff, seek_ff}
                  : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // flip-flops

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < PRESETS; i++) preset_ff[i] <= PRESET_RESET;
        end else if (wr_preset) begin
            preset_ff[I_ADDR] <= I_WDATA[4:0];
        end
    end

    // mechanical positions survive reset; only a position write makes them trusted
    always_ff @(posedge I_CLOCK) begin
        if (wr_pos) pos_ff <= wr_pos_val;
        else if (pos_known_ff) pos_ff <= nxt_pos;
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            pos_known_ff <= 1'b0;
            req_chan_ff  <= 4'h0;
            seek_ff      <= 1'b0;
            drive_ff     <= '0;
            motor_ff     <= 1'b0;
            mute_ff      <= 1'b0;
            energize_ff  <= 4'h0;
            rdata_ff     <= 32'h0000_0000;
        end else begin
            pos_known_ff <= pos_known_ff || wr_pos;
            req_chan_ff  <= nxt_req_chan;
            seek_ff      <= nxt_seek;
            drive_ff     <= nxt_drive;
            motor_ff     <= nxt_motor;
            mute_ff      <= nxt_mute;
            energize_ff  <= pos_known_ff ? nxt_pos.chan : 4'h0;
            rdata_ff     <= I_RD ? rd_mux : 32'h0000_0000;
        end
    end

    assign O_RDATA                = rdata_ff;
    assign O_CHANNEL_SEEK_REQUEST = seek_ff;
    assign O_DRIVES               = drive_ff;
    assign O_MOTOR_RUN            = motor_ff;
    assign O_MUTE                 = mute_ff;
    assign O_CHANNEL_ENERGIZE     = energize_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    motor_any_drive_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        motor_ff == (|drive_ff)) else $error("motor run does not follow drives");
    mute_motor_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        motor_ff |-> mute_ff) else $error("motor runs without mute");
    seek_inhibit_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        seek_ff |-> !(drive_ff.tens || drive_ff.units || drive_ff.tenths))
        else $error("digit drive active during channel seek");
    seek_chan_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        seek_ff == drive_ff.chan) else $error("channel drive differs from seek");
    seek_release_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (pos_known_ff && !wr_pos && req_chan_ff == pos_ff.chan) |=> !seek_ff)
        else $error("seek request held after match");
    track_mute_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_TRACK_MODE == 2'(TRK_OFF) || I_TRACK_MODE == 2'(TRK_RUN)) |=> mute_ff)
        else $error("mute missing in tracking mode");
    track_run_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_TRACK_MODE == 2'(TRK_RUN) && pos_known_ff && !nxt_seek && !seek_ff)
        |=> drive_ff.tens) else $error("10 mc drive idle in run mode");
    track_off_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_TRACK_MODE == 2'(TRK_OFF)) |=> !drive_ff.tens)
        else $error("10 mc drive active outside normal");
    return_blank_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (pos_ff.tens >= PHASE2_END && pos_known_ff && !seek_ff && !nxt_seek
         && I_TRACK_MODE == 2'(TRK_NORMAL)) |=> drive_ff.tens)
        else $error("10 mc seek stopped in return travel");
    step_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (pos_known_ff && !motor_ff && !wr_pos) |=> $stable(pos_ff))
        else $error("position moved with motor stopped");
    reset_quiet_a: assert property (@(posedge I_CLOCK)
        !I_RST_N |=> (!motor_ff && !mute_ff && drive_ff == '0))
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// file: verification/cap_operator_model.sv
// operator selector switches and mechanism step source facing the sequencer
`default_nettype none
module cap_operator_model (
    input  wire logic       i_clock,       // system clock
    input  wire logic [3:0] i_sel_cmd,     // wanted local selector setting
    input  wire logic [3:0] i_remote_cmd,  // wanted remote selector code
    input  wire logic [1:0] i_mode_cmd,    // wanted tracking mode
    input  wire logic [3:0] i_gap,         // cycles per mechanical step, 0 stalls
    input  wire logic       i_motor_run,   // motor run seen from the block
    output var  logic [3:0] o_local_sel,   // local selector position
    output var  logic [3:0] o_remote_code, // remote four-line code
    output var  logic [1:0] o_track_mode,  // tracking mode switch
    output var  logic       o_motor_step   // one pulse per step
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff = 4'h0;
    ////////////////////////////////////////////////////////////////////////////
    // a switch holds its setting until the operator moves it again
    always @(posedge i_clock) begin
        o_local_sel   <= i_sel_cmd;
        o_remote_code <= i_remote_cmd;
        o_track_mode  <= i_mode_cmd;
    end
    ////////////////////////////////////////////////////////////////////////////
    // a stalled mechanism gives no steps, so a drive can never finish by luck
    always @(posedge i_clock) begin
        cnt_ff       <= (i_gap == 4'h0 || cnt_ff >= i_gap - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
        o_motor_step <= i_motor_run && i_gap != 4'h0 && cnt_ff == 4'h0;
    end
endmodule
`default_nettype wire

// file: verification/cap_sequencer_test.sv
// self-checking bench for the channel autopositioner sequencer
`default_nettype none
module cap_sequencer_test import cap_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    logic [ADDR_W-1:0]   addr = '0;
    logic [DATA_W-1:0]   wdata = '0;
    logic [DATA_W-1:0]   rdata;
    logic                wr = 1'b0;
    logic                rd_s = 1'b0;
    logic [3:0]          sel_cmd = 4'h0;
    logic [3:0]          remote_cmd = 4'h0;
    logic [1:0]          mode_cmd = 2'h0;
    logic [3:0]          gap = 4'h2;
    logic [3:0]          local_sel, remote_code, energize;
    logic [1:0]          track_mode;
    logic                step, seek, motor, mute;
    cap_drive_type       drives;
    int                  num_errors = 0;
    int                  n_tests = 0;

    always #20 clock = ~clock;

    cap_sequencer cap_sequencer_inst (.I_CLOCK(clock), .I_RST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd_s), .O_RDATA(rdata), .I_LOCAL_SEL(local_sel),
        .I_REMOTE_CODE(remote_code), .I_TRACK_MODE(track_mode), .I_MOTOR_STEP(step),
        .O_CHANNEL_SEEK_REQUEST(seek), .O_DRIVES(drives), .O_MOTOR_RUN(motor),
        .O_MUTE(mute), .O_CHANNEL_ENERGIZE(energize));
    cap_operator_model cap_operator_model_inst (.i_clock(clock), .i_sel_cmd(sel_cmd),
        .i_remote_cmd(remote_cmd), .i_mode_cmd(mode_cmd), .i_gap(gap), .i_motor_run(motor),
        .o_local_sel(local_sel), .o_remote_code(remote_code), .o_track_mode(track_mode),
        .o_motor_step(step));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic note(input string name);
        $display("test %s done", name);
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        #1 check("read data", exp, rdata);
    endtask
    task automatic preset(input logic [5:0] ch, input logic [4:0] t, u, f);
        wr_reg(ADDR_PRESET0 + ch * 6'h03, {27'h0, t});
        wr_reg(ADDR_PRESET0 + ch * 6'h03 + 6'h01, {27'h0, u});
        wr_reg(ADDR_PRESET0 + ch * 6'h03 + 6'h02, {27'h0, f});
    endtask
    function automatic logic [31:0] pos(input logic [3:0] c, input logic [5:0] t,
                                        input logic [3:0] u, input logic [3:0] f);
        pos = {12'h000, f, u, 2'b00, t, c};
    endfunction
    task automatic select(input logic [3:0] s, input logic [3:0] r, input logic [3:0] g);
        @(posedge clock);
        sel_cmd    <= s;
        remote_cmd <= r;
        gap        <= g;
    endtask
    task automatic set_mode(input cap_track_type m);
        @(posedge clock);
        mode_cmd <= m;
    endtask
    // every wait is bounded so a stuck drive ends the run instead of hanging it
    task automatic wait_motor(input logic lvl, input int lim);
        int i;
        i = 0;
        while (motor !== lvl && i < lim) begin
            @(posedge clock);
            #1 i++;
        end
        if (motor !== lvl) begin
            $display("MISMATCH motor wait expected %b seen %b", lvl, motor);
            num_errors++;
            stop_test();
        end
    endtask
    task automatic cycle(input logic [31:0] exp);
        wait_motor(1'b1, 10);
        wait_motor(1'b0, 3000);
        rd_reg(ADDR_POSITION, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // cycle-by-cycle relations between the drive outputs
    always @(negedge clock) begin
        if (rst_n === 1'b1) begin
            check("motor vs drives", 32'(|drives), 32'(motor));
            check("seek vs channel drive", 32'(seek), 32'(drives.chan));
            if (motor === 1'b1) check("mute", 32'h1, 32'(mute));
            if (seek === 1'b1) check("digit drives", 32'h0, 32'(drives[2:0]));
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 check("outputs after reset", 32'h0, 32'({drives, seek, motor, mute}));
        rd_reg(ADDR_PRESET0, 32'h0);
        preset(6'h03, 5'h02, 5'h05, 5'h07);
        preset(6'h05, 5'h0C, 5'h00, 5'h09);
        preset(6'h06, 5'h01, 5'h04, 5'h02);
        rd_reg(ADDR_PRESET0 + 6'h0A, 32'h5);
        wr_reg(6'h3F, 32'hFFFF_FFFF);
        rd_reg(6'h3F, 32'h0);
        note("registers");
        select(4'h3, 4'h0, 4'h2);
        repeat (10) @(posedge clock);
        #1 check("idle while positions unknown", 32'h0, 32'(motor));
        wr_reg(ADDR_POSITION, pos(4'h0, 6'h00, 4'h0, 4'h0));
        cycle(pos(4'h3, 6'h02, 4'h5, 4'h7));
        check("channel energize", 32'h3, 32'(energize));
        note("local select");
        select(4'hB, 4'h5, 4'h5);
        cycle(pos(4'h5, 6'h0C, 4'h0, 4'h9));
        note("remote select");
        select(4'h6, 4'h5, 4'h5);
        cycle(pos(4'h6, 6'h01, 4'h4, 4'h2));
        note("tens return travel");
        select(4'hB, 4'h0, 4'h2);
        repeat (10) @(posedge clock);
        #1 check("invalid remote ignored", 32'h0, 32'(motor));
        set_mode(TRK_OFF);
        repeat (3) @(posedge clock);
        #1 check("mute in off", 32'h1, 32'(mute));
        check("no drives in off", 32'h0, 32'(drives));
        set_mode(TRK_RUN);
        wait_motor(1'b1, 10);
        check("run drives tens", 32'h4, 32'(drives));
        repeat (60) @(posedge clock);
        #1 check("run keeps going", 32'h4, 32'(drives));
        set_mode(TRK_OFF);
        wait_motor(1'b0, 10);
        check("mute after run", 32'h1, 32'(mute));
        set_mode(TRK_NORMAL);
        cycle(pos(4'h6, 6'h01, 4'h4, 4'h2));
        @(posedge clock);
        #1 check("mute released", 32'h0, 32'(mute));
        note("tracking");
        select(4'h1, 4'h0, 4'h0);
        wait_motor(1'b1, 10);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check("outputs in reset", 32'h0, 32'({drives, seek, motor, mute}));
        @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(ADDR_POSITION, pos(4'h6, 6'h01, 4'h4, 4'h2));
        check("idle after reset", 32'h0, 32'(motor));
        note("reset mid seek");
        stop_test();
    end
endmodule
`default_nettype wire
